// ==== inc/bus_timing_pkg.sv ====
package bus_timing_pkg;
   // register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFS_ZONE_TWO_CFG = 8'h00;
   localparam logic [7:0] OFS_FLASH_CFG = 8'h04;
   localparam logic [7:0] OFS_IO_CFG = 8'h08;
   localparam logic [7:0] OFS_WRITE_MODE = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [15:0] CFG_RESET = 16'h069f;
   localparam logic [15:0] CFG_WRITABLE = 16'h0eff;
   localparam logic [2:0] WRITE_MODE_RESET = 3'h7;
   localparam int EARLY_WRITE_BIT = 0;
   // zone configuration field positions
   localparam int DELAY_LSB = 0;
   localparam int DELAY_W = 3;
   localparam int HOLD_LSB = 3;
   localparam int HOLD_W = 2;
   localparam int BURST_READ_BIT = 5;
   localparam int BURST_WAIT_BIT = 6;
   localparam int WIDTH_BIT = 7;
   localparam int POST_IDLE_BIT = 9;
   localparam int PRE_IDLE_BIT = 10;
   localparam int FAST_READ_BIT = 11;
   // cpu address map
   localparam logic [23:0] FLASH_PROG_LO = 24'h000000;
   localparam logic [23:0] FLASH_PROG_HI = 24'h03ffff;
   localparam logic [23:0] FLASH_DATA_LO = 24'h0e0000;
   localparam logic [23:0] FLASH_DATA_HI = 24'h0e1fff;
   localparam logic [23:0] RAM_A_LO = 24'h0e8000;
   localparam logic [23:0] RAM_A_HI = 24'h0e91ff;
   localparam logic [23:0] RAM_B_LO = 24'h0ec000;
   localparam logic [23:0] RAM_B_HI = 24'h0eebff;
   localparam logic [23:0] PERIPH_A_LO = 24'h0ef000;
   localparam logic [23:0] PERIPH_A_HI = 24'h0ef1ff;
   localparam logic [23:0] PERIPH_B_LO = 24'hff0000;
   localparam logic [23:0] PERIPH_B_HI = 24'hfffbff;
   localparam logic [23:0] IO_LO = 24'hfffb00;
   localparam logic [23:0] IO_HI = 24'hfffbff;
   // beat lengths in clocks, access cycle plus waits
   localparam logic [3:0] FAST_READ_BEAT = 4'h1;
   localparam logic [3:0] NORMAL_BEAT_MIN = 4'h2;
   localparam logic [3:0] FLASH_FAST_WRITE_BEAT = 4'h2;
   localparam logic [3:0] PERIPH_BEAT = 4'h2;
   localparam logic [3:0] RAM_BEAT = 4'h1;
   localparam int FLASH_FAST_MAX_MHZ = 24;
   typedef enum logic [2:0] {ZONE_NONE, ZONE_FLASH, ZONE_RAM, ZONE_PERIPH, ZONE_IO, ZONE_TWO} zone_t;
   typedef enum logic [1:0] {S_READY, S_IDLE, S_BEAT, S_HOLD} seq_state_t;
endpackage

// ==== hw/cycle_counter.sv ====
`timescale 1ns/100ps
module cycle_counter #(
   parameter int W = 4
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic load_i,
   input wire logic [W-1:0] value_i,
   output logic last_o
);
   typedef struct packed {
      logic [W-1:0] count;
   } cnt_t;
   cnt_t c;
   cnt_t next_c;

   always_comb begin
      next_c = c;
      if (load_i) begin
         next_c.count = value_i;
      end else if (c.count != '0) begin
         next_c.count = c.count - W'(1);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         c <= '0;
      end else begin
         c <= next_c;
      end
   end

   assign last_o = (c.count == W'(1));
endmodule

// ==== hw/zone_timing_decode.sv ====
`timescale 1ns/100ps
module zone_timing_decode #(
   parameter logic [23:0] ZONE_TWO_LO = 24'h400000,
   parameter logic [23:0] ZONE_TWO_HI = 24'h7fffff
) (
   input wire logic [23:0] addr_i,
   input wire logic write_i,
   input wire logic wide_i,
   input wire logic [15:0] zone_two_cfg_i,
   input wire logic [15:0] flash_cfg_i,
   input wire logic [15:0] io_cfg_i,
   input wire logic early_write_i,
   output bus_timing_pkg::zone_t zone_o,
   output logic [3:0] beat_o,
   output logic [1:0] hold_o,
   output logic [1:0] burst_len_o,
   output logic two_beats_o,
   output logic burst_o,
   output logic pre_idle_o,
   output logic post_idle_o
);
   import bus_timing_pkg::*;
   logic [15:0] cfg;
   logic fast_read_enable;
   logic [3:0] delay;

   always_comb begin
      zone_o = ZONE_NONE;
      cfg = zone_two_cfg_i;
      if ((addr_i <= FLASH_PROG_HI) || (addr_i >= FLASH_DATA_LO && addr_i <= FLASH_DATA_HI)) begin
         zone_o = ZONE_FLASH;
         cfg = flash_cfg_i;
      end else if ((addr_i >= RAM_A_LO && addr_i <= RAM_A_HI) || (addr_i >= RAM_B_LO && addr_i <= RAM_B_HI)) begin
         zone_o = ZONE_RAM;
      end else if (addr_i >= IO_LO && addr_i <= IO_HI) begin
         zone_o = ZONE_IO;
         cfg = io_cfg_i;
      end else if ((addr_i >= PERIPH_A_LO && addr_i <= PERIPH_A_HI) || addr_i >= PERIPH_B_LO) begin
         zone_o = ZONE_PERIPH;
      end else if (addr_i >= ZONE_TWO_LO && addr_i <= ZONE_TWO_HI) begin
         zone_o = ZONE_TWO;
      end
      fast_read_enable = cfg[FAST_READ_BIT];
      delay = {1'b0, cfg[DELAY_LSB +: DELAY_W]};
      hold_o = fast_read_enable ? 2'h0 : cfg[HOLD_LSB +: HOLD_W];
      pre_idle_o = cfg[PRE_IDLE_BIT];
      post_idle_o = cfg[POST_IDLE_BIT];
      two_beats_o = wide_i && !cfg[WIDTH_BIT];
      burst_o = two_beats_o && !write_i && cfg[BURST_READ_BIT] && !fast_read_enable;
      burst_len_o = cfg[BURST_WAIT_BIT] ? 2'h2 : 2'h1;
      // fast read is one clock, normal at least two plus waits
      if (fast_read_enable) begin
         beat_o = write_i ? NORMAL_BEAT_MIN : FAST_READ_BEAT;
      end else begin
         beat_o = NORMAL_BEAT_MIN + delay;
      end
      unique case (zone_o)
         ZONE_FLASH: begin
            two_beats_o = 1'b0;
            burst_o = 1'b0;
            if (fast_read_enable) begin
               beat_o = write_i ? FLASH_FAST_WRITE_BEAT : FAST_READ_BEAT;
            end else begin
               beat_o = NORMAL_BEAT_MIN + delay + {3'h0, write_i && early_write_i};
            end
         end
         ZONE_RAM, ZONE_NONE: begin
            beat_o = RAM_BEAT;
            hold_o = 2'h0;
            two_beats_o = 1'b0;
            burst_o = 1'b0;
            pre_idle_o = 1'b0;
            post_idle_o = 1'b0;
         end
         ZONE_PERIPH: begin
            beat_o = PERIPH_BEAT;
            hold_o = 2'h0;
            two_beats_o = 1'b0;
            burst_o = 1'b0;
            pre_idle_o = 1'b1;
            post_idle_o = 1'b0;
         end
         ZONE_IO, ZONE_TWO: begin
         end
      endcase
   end
endmodule

// ==== hw/static_zone_bus_timing.sv ====
// Operation
// - zone two config governs chip-select two accesses
// - zone two register 16-bit, bits 0eff RW, resets 069f
// - delay field adds zero to seven waits
// - fast read ignores delay and hold
// - hold field appends zero to three holds
// - burst read for 16-bit reads, 8-bit zone
// - burst wait adds one burst wait state
// - width bit clear 8-bit, set 16-bit
// - fast read one clock, normal two plus
// - post idle after cycle on zone change
// - pre idle before cycle on zone change
// - flash timing for flash address ranges
// - flash fast read is single cycle
// - flash normal read: delay+1 waits, hold
// - flash fast write: one wait, no hold
// - flash normal write: delay+1 or +2 waits
// - ram accesses always one cycle
// - peripherals: one wait, one pre idle
// - io zone timing from io config
// - write mode config resets to early write
`timescale 1ns/100ps
module static_zone_bus_timing #(
   parameter logic [23:0] ZONE_TWO_LO = 24'h400000,
   parameter logic [23:0] ZONE_TWO_HI = 24'h7fffff
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic acc_req_i,
   input wire logic [23:0] acc_addr_i,
   input wire logic acc_write_i,
   input wire logic acc_wide_i,
   output logic acc_done_o,
   output logic acc_busy_o,
   output logic bus_strobe_o,
   output logic bus_hold_o,
   output logic bus_idle_o,
   output logic second_beat_o,
   output logic zone_two_chip_select_n_o
);
   import bus_timing_pkg::*;

   typedef struct packed {
      seq_state_t state;
      logic [15:0] zone_two_cfg;
      logic [15:0] flash_cfg;
      logic [15:0] io_cfg;
      logic [2:0] write_mode;
      logic wpend;
      logic [7:0] waddr;
      logic [31:0] rdata;
      logic ready;
      zone_t zone;
      zone_t last_zone;
      logic last_post;
      logic cur_post;
      logic [3:0] beat_len;
      logic [1:0] hold_len;
      logic [1:0] burst_len;
      logic two_beats;
      logic burst;
      logic beat;
      logic done;
      logic strobe;
      logic hold;
      logic idle;
      logic cs2_n;
      logic busy;
   } state_t;

   localparam state_t ST_RESET = '{
      state: S_READY,
      zone_two_cfg: CFG_RESET,
      flash_cfg: CFG_RESET,
      io_cfg: CFG_RESET,
      write_mode: WRITE_MODE_RESET,
      ready: 1'b1,
      zone: ZONE_NONE,
      last_zone: ZONE_NONE,
      cs2_n: 1'b1,
      default: '0
   };

   state_t s;
   state_t n;

   zone_t dec_zone;
   logic [3:0] dec_beat;
   logic [1:0] dec_hold;
   logic [1:0] dec_burst_len;
   logic dec_two;
   logic dec_burst;
   logic dec_pre;
   logic dec_post;
   logic cnt_load;
   logic [3:0] cnt_value;
   logic cnt_last;
   logic take;
   logic accept;
   logic changed;
   logic [1:0] idles;
   logic end_beat;

   zone_timing_decode #(
      .ZONE_TWO_LO(ZONE_TWO_LO),
      .ZONE_TWO_HI(ZONE_TWO_HI)
   ) u_decode (
      .addr_i(acc_addr_i),
      .write_i(acc_write_i),
      .wide_i(acc_wide_i),
      .zone_two_cfg_i(s.zone_two_cfg),
      .flash_cfg_i(s.flash_cfg),
      .io_cfg_i(s.io_cfg),
      .early_write_i(s.write_mode[EARLY_WRITE_BIT]),
      .zone_o(dec_zone),
      .beat_o(dec_beat),
      .hold_o(dec_hold),
      .burst_len_o(dec_burst_len),
      .two_beats_o(dec_two),
      .burst_o(dec_burst),
      .pre_idle_o(dec_pre),
      .post_idle_o(dec_post)
   );

   cycle_counter #(
      .W(4)
   ) u_count (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .load_i(cnt_load),
      .value_i(cnt_value),
      .last_o(cnt_last)
   );

   assign take = hsel_i && hready_i && htrans_i[1];
   assign accept = (s.state == S_READY) && acc_req_i && !s.done;
   assign changed = (dec_zone != s.last_zone);
   // peripheral idle always, others only on a zone change
   assign idles = {1'b0, (dec_zone == ZONE_PERIPH) || (changed && dec_pre)}
                + {1'b0, changed && s.last_post};

   always_comb begin
      n = s;
      n.done = 1'b0;
      n.ready = 1'b1;
      cnt_load = 1'b0;
      cnt_value = s.beat_len;
      end_beat = 1'b0;
      // register writes land in the data phase
      n.wpend = take && hwrite_i && (hsize_i == 3'h2) && (haddr_i[31:8] == 24'h000000);
      n.waddr = haddr_i[7:0];
      if (s.wpend) begin
         case (s.waddr)
            OFS_ZONE_TWO_CFG: n.zone_two_cfg = hwdata_i[15:0] & CFG_WRITABLE;
            OFS_FLASH_CFG: n.flash_cfg = hwdata_i[15:0] & CFG_WRITABLE;
            OFS_IO_CFG: n.io_cfg = hwdata_i[15:0] & CFG_WRITABLE;
            OFS_WRITE_MODE: n.write_mode = hwdata_i[2:0];
            default: begin
            end
         endcase
      end

      unique case (s.state)
         S_READY: begin
            if (accept) begin
               n.zone = dec_zone;
               n.beat_len = dec_beat;
               n.hold_len = dec_hold;
               n.burst_len = dec_burst_len;
               n.two_beats = dec_two;
               n.burst = dec_burst;
               n.cur_post = dec_post;
               n.beat = 1'b0;
               cnt_load = 1'b1;
               if (idles != 2'h0) begin
                  n.state = S_IDLE;
                  cnt_value = {2'h0, idles};
               end else begin
                  n.state = S_BEAT;
                  cnt_value = dec_beat;
               end
            end
         end
         S_IDLE: begin
            if (cnt_last) begin
               n.state = S_BEAT;
               cnt_load = 1'b1;
               cnt_value = s.beat_len;
            end
         end
         S_BEAT: begin
            if (cnt_last) begin
               if (!s.beat && s.two_beats && s.burst) begin
                  n.beat = 1'b1;
                  cnt_load = 1'b1;
                  cnt_value = {2'h0, s.burst_len};
               end else if (s.hold_len != 2'h0) begin
                  n.state = S_HOLD;
                  cnt_load = 1'b1;
                  cnt_value = {2'h0, s.hold_len};
               end else begin
                  end_beat = 1'b1;
               end
            end
         end
         S_HOLD: begin
            if (cnt_last) begin
               end_beat = 1'b1;
            end
         end
      endcase

      if (end_beat) begin
         if (!s.beat && s.two_beats) begin
            n.beat = 1'b1;
            n.state = S_BEAT;
            cnt_load = 1'b1;
            cnt_value = s.beat_len;
         end else begin
            n.state = S_READY;
            n.beat = 1'b0;
            n.done = 1'b1;
            n.last_zone = s.zone;
            n.last_post = s.cur_post;
         end
      end

      n.strobe = (n.state == S_BEAT);
      n.hold = (n.state == S_HOLD);
      n.idle = (n.state == S_IDLE);
      n.busy = (n.state != S_READY);
      n.cs2_n = !((n.state == S_BEAT || n.state == S_HOLD) && n.zone == ZONE_TWO);

      // read data taken from the updated copy so a write is seen at once
      if (take && !hwrite_i) begin
         n.rdata = 32'h00000000;
         if (haddr_i[31:8] == 24'h000000) begin
            case (haddr_i[7:0])
               OFS_ZONE_TWO_CFG: n.rdata = {16'h0000, n.zone_two_cfg};
               OFS_FLASH_CFG: n.rdata = {16'h0000, n.flash_cfg};
               OFS_IO_CFG: n.rdata = {16'h0000, n.io_cfg};
               OFS_WRITE_MODE: n.rdata = {29'h00000000, n.write_mode};
               OFS_STATUS: n.rdata = {28'h0000000, s.last_zone, s.state != S_READY};
               default: n.rdata = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         s <= ST_RESET;
      end else begin
         s <= n;
      end
   end

   assign hrdata_o = s.rdata;
   assign hreadyout_o = s.ready;
   assign hresp_o = 1'b0;
   assign acc_done_o = s.done;
   assign acc_busy_o = s.busy;
   assign bus_strobe_o = s.strobe;
   assign bus_hold_o = s.hold;
   assign bus_idle_o = s.idle;
   assign second_beat_o = s.beat;
   assign zone_two_chip_select_n_o = s.cs2_n;

   // strobe run length, read only by the checks below
   logic [4:0] run;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         run <= 5'h00;
      end else begin
         run <= s.strobe ? run + 5'h01 : 5'h00;
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_ram_go;
      accept && dec_zone == ZONE_RAM && idles == 2'h0;
   endsequence
   sequence s_single_beat;
      s.strobe ##1 (!s.strobe && s.done);
   endsequence
   sequence s_periph_go;
      accept && dec_zone == ZONE_PERIPH && idles == 2'h1;
   endsequence
   sequence s_periph_run;
      s.idle ##1 s.strobe [*2] ##1 s.done;
   endsequence

   cfg_reset_a: assert property (disable iff (1'b0) sys_rst_i |=>
      s.zone_two_cfg == CFG_RESET && s.write_mode == WRITE_MODE_RESET)
      else $error("config reset value wrong");
   chip_select_a: assert property (!zone_two_chip_select_n_o |->
      s.zone == ZONE_TWO && (s.strobe || s.hold))
      else $error("chip select two outside zone two cycle");
   beat_len_a: assert property ($fell(s.strobe) && !s.two_beats |->
      $past(run) + 5'h01 == {1'b0, s.beat_len})
      else $error("beat length differs from decoded length");
   flash_read_a: assert property (dec_zone == ZONE_FLASH && !acc_write_i && !s.flash_cfg[FAST_READ_BIT] |->
      dec_beat == {1'b0, s.flash_cfg[2:0]} + 4'h2 && dec_hold == s.flash_cfg[4:3])
      else $error("flash normal read timing wrong");
   flash_fast_a: assert property (dec_zone == ZONE_FLASH && s.flash_cfg[FAST_READ_BIT] |->
      dec_hold == 2'h0 && dec_beat == (acc_write_i ? 4'h2 : 4'h1))
      else $error("flash fast timing wrong");
   flash_write_a: assert property (dec_zone == ZONE_FLASH && acc_write_i && !s.flash_cfg[FAST_READ_BIT] |->
      dec_beat == {1'b0, s.flash_cfg[2:0]} + 4'h2 + {3'h0, s.write_mode[0]})
      else $error("flash write waits wrong");
   ram_cycle_a: assert property (s_ram_go |=> s_single_beat)
      else $error("ram access not one cycle");
   periph_a: assert property (s_periph_go |=> s_periph_run)
      else $error("peripheral timing wrong");
   zone_fast_a: assert property (dec_zone == ZONE_TWO && s.zone_two_cfg[FAST_READ_BIT] && !acc_write_i |->
      dec_beat == 4'h1 && dec_hold == 2'h0)
      else $error("zone two fast read not one clock");
   zone_normal_a: assert property (dec_zone == ZONE_TWO && !s.zone_two_cfg[FAST_READ_BIT] |->
      dec_beat == {1'b0, s.zone_two_cfg[2:0]} + 4'h2 && dec_hold == s.zone_two_cfg[4:3])
      else $error("zone two normal timing wrong");
   burst_gate_a: assert property (dec_zone == ZONE_TWO && dec_burst |->
      !s.zone_two_cfg[FAST_READ_BIT] && !s.zone_two_cfg[WIDTH_BIT] && s.zone_two_cfg[BURST_READ_BIT])
      else $error("burst without its enables");
   pre_idle_a: assert property (accept && changed && dec_pre |=> s.idle)
      else $error("missing pre idle cycle");
   post_idle_a: assert property (accept && changed && s.last_post |=> s.idle)
      else $error("missing post idle cycle");
   io_cfg_a: assert property (dec_zone == ZONE_IO |->
      dec_hold == (s.io_cfg[FAST_READ_BIT] ? 2'h0 : s.io_cfg[4:3]))
      else $error("io zone not using io config");
endmodule

// ==== bench/zone_mem_model.sv ====
`timescale 1ns/100ps
module zone_mem_model (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic frame_end_i,
   input wire logic bus_strobe_i,
   input wire logic bus_hold_i,
   input wire logic bus_idle_i,
   input wire logic second_beat_i,
   input wire logic chip_select_n_i,
   output logic [5:0] strobe_cnt_o,
   output logic [3:0] hold_cnt_o,
   output logic [3:0] idle_cnt_o,
   output logic [5:0] select_cnt_o,
   output logic second_seen_o
);
   // external part sees only phase levels; counts restart after each access
   always @(posedge mclk_i) begin
      if (sys_rst_i || frame_end_i) begin
         strobe_cnt_o <= 6'h00;
         hold_cnt_o <= 4'h0;
         idle_cnt_o <= 4'h0;
         select_cnt_o <= 6'h00;
         second_seen_o <= 1'b0;
      end else begin
         strobe_cnt_o <= strobe_cnt_o + {5'h00, bus_strobe_i};
         hold_cnt_o <= hold_cnt_o + {3'h0, bus_hold_i};
         idle_cnt_o <= idle_cnt_o + {3'h0, bus_idle_i};
         select_cnt_o <= select_cnt_o + {5'h00, !chip_select_n_i};
         second_seen_o <= second_seen_o | second_beat_i;
      end
   end
endmodule

// ==== bench/static_zone_bus_timing_tb_top.sv ====
`timescale 1ns/100ps
module static_zone_bus_timing_tb_top;
   import bus_timing_pkg::*;
   logic mclk_i = 1'b0, sys_rst_i = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic hreadyout, hresp, acc_req = 1'b0, acc_write = 1'b0, acc_wide = 1'b0;
   logic [23:0] acc_addr = 24'h0;
   logic acc_done, acc_busy, strobe, hold, idle, second, cs_n;
   logic [5:0] st_cnt, sel_cnt;
   logic [3:0] ho_cnt, id_cnt;
   logic sec_seen;
   logic [31:0] exp_rd_q[$];
   logic [31:0] exp_acc_q[$];
   logic [15:0] z2_cfg = CFG_RESET, fl_cfg = CFG_RESET, io_cfg = CFG_RESET;
   logic [2:0] wmode = WRITE_MODE_RESET;
   zone_t prev_zone = ZONE_NONE;
   logic prev_post = 1'b0, rd_phase = 1'b0;
   int n_mismatch = 0, n_checks = 0, lat = 0, seed = 71809;
   int n_busy = 0;
   logic [31:0] exp_acc;
   logic [15:0] dir_cfg[4] = '{16'h0060, 16'h0020, 16'h0800, 16'h0e1a};

   always #2 mclk_i = ~mclk_i;

   static_zone_bus_timing dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
      .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .acc_req_i(acc_req),
      .acc_addr_i(acc_addr), .acc_write_i(acc_write), .acc_wide_i(acc_wide), .acc_done_o(acc_done),
      .acc_busy_o(acc_busy), .bus_strobe_o(strobe), .bus_hold_o(hold), .bus_idle_o(idle),
      .second_beat_o(second), .zone_two_chip_select_n_o(cs_n));

   zone_mem_model mem (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .frame_end_i(acc_done),
      .bus_strobe_i(strobe), .bus_hold_i(hold), .bus_idle_i(idle), .second_beat_i(second),
      .chip_select_n_i(cs_n), .strobe_cnt_o(st_cnt), .hold_cnt_o(ho_cnt), .idle_cnt_o(id_cnt),
      .select_cnt_o(sel_cnt), .second_seen_o(sec_seen));

   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t reg got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_acc(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t access got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // one whole-word transfer; read data is judged by the monitor below
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge mclk_i);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'b010;
      @(posedge mclk_i);
      while (hreadyout !== 1'b1) @(posedge mclk_i);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge mclk_i);
      while (hreadyout !== 1'b1) @(posedge mclk_i);
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      ahb(a, 1'b1, d);
      if (a == OFS_ZONE_TWO_CFG) z2_cfg = d[15:0] & CFG_WRITABLE;
      if (a == OFS_FLASH_CFG) fl_cfg = d[15:0] & CFG_WRITABLE;
      if (a == OFS_IO_CFG) io_cfg = d[15:0] & CFG_WRITABLE;
      if (a == OFS_WRITE_MODE) wmode = d[2:0];
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      exp_rd_q.push_back(exp);
      ahb(a, 1'b0, 32'h0);
   endtask

   function automatic logic [31:0] expect_acc(input logic [23:0] a, input logic wr, input logic wide);
      zone_t z;
      logic [15:0] c;
      logic chg, two, burst, fast;
      int beat, h, id, st, ho, cs;
      if (a >= IO_LO && a <= IO_HI) z = ZONE_IO;
      else if (a <= FLASH_PROG_HI || (a >= FLASH_DATA_LO && a <= FLASH_DATA_HI)) z = ZONE_FLASH;
      else if ((a >= RAM_A_LO && a <= RAM_A_HI) || (a >= RAM_B_LO && a <= RAM_B_HI)) z = ZONE_RAM;
      else if ((a >= PERIPH_A_LO && a <= PERIPH_A_HI) || a >= PERIPH_B_LO) z = ZONE_PERIPH;
      else if (a >= 24'h400000 && a <= 24'h7fffff) z = ZONE_TWO;
      else z = ZONE_NONE;
      c = (z == ZONE_FLASH) ? fl_cfg : (z == ZONE_IO) ? io_cfg : (z == ZONE_TWO) ? z2_cfg : 16'h0000;
      fast = c[FAST_READ_BIT];
      chg = (z != prev_zone);
      h = fast ? 0 : int'(c[HOLD_LSB+:HOLD_W]);
      beat = fast ? (wr ? 2 : 1) : int'(c[DELAY_LSB+:DELAY_W]) + 2 + ((z == ZONE_FLASH && wr) ? int'(wmode[0]) : 0);
      if (z == ZONE_RAM || z == ZONE_NONE) begin
         beat = 1;
         h = 0;
      end
      if (z == ZONE_PERIPH) begin
         beat = 2;
         h = 0;
      end
      two = wide && !c[WIDTH_BIT] && (z == ZONE_IO || z == ZONE_TWO);
      burst = two && !wr && c[BURST_READ_BIT] && !fast;
      st = beat + (two ? (burst ? 1 + int'(c[BURST_WAIT_BIT]) : beat) : 0);
      ho = (two && !burst) ? 2 * h : h;
      id = int'(z == ZONE_PERIPH || (chg && c[PRE_IDLE_BIT])) + int'(chg && prev_post);
      cs = (z == ZONE_TWO) ? st + ho : 0;
      prev_zone = z;
      prev_post = c[POST_IDLE_BIT];
      return {two, id[3:0], st[5:0], ho[3:0], cs[5:0], 7'(id + st + ho + 2)};
   endfunction

   task automatic do_acc(input logic [23:0] a, input logic wr, input logic wide);
      exp_acc_q.push_back(expect_acc(a, wr, wide));
      @(posedge mclk_i);
      acc_req <= 1'b1;
      acc_addr <= a;
      acc_write <= wr;
      acc_wide <= wide;
      @(posedge mclk_i);
      while (acc_done !== 1'b1) @(posedge mclk_i);
      acc_req <= 1'b0;
   endtask

   // result monitor: read data in the data phase, access counts at done
   always @(posedge mclk_i) begin
      if (rd_phase && hreadyout === 1'b1) begin
         cmp_rd(hrdata, exp_rd_q.pop_front());
         cmp_rd({31'h0, hresp}, 32'h0);
      end
      if (hreadyout === 1'b1) rd_phase = hsel && htrans[1] && !hwrite;
      if (acc_req) lat = lat + 1;
      if (acc_busy === 1'b1) n_busy = n_busy + 1;
      if (acc_done === 1'b1) begin
         exp_acc = exp_acc_q.pop_front();
         cmp_acc({sec_seen, id_cnt, st_cnt, ho_cnt, sel_cnt, 7'(lat)}, exp_acc);
         cmp_acc({25'h0, 7'(n_busy)}, {25'h0, exp_acc[6:0] - 7'h02});
         lat = 0;
         n_busy = 0;
      end
   end

   initial begin
      #(4 * 20000);
      n_mismatch++;
      finish_test();
   end

   initial begin
      repeat (3) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      reg_rd(OFS_ZONE_TWO_CFG, {16'h0, CFG_RESET});
      reg_rd(OFS_FLASH_CFG, {16'h0, CFG_RESET});
      reg_rd(OFS_IO_CFG, {16'h0, CFG_RESET});
      reg_rd(OFS_WRITE_MODE, 32'h7);
      reg_rd(8'h14, 32'h0);
      reg_wr(OFS_ZONE_TWO_CFG, 32'hffffffff);
      reg_rd(OFS_ZONE_TWO_CFG, 32'h00000eff);
      reg_wr(OFS_FLASH_CFG, 32'h008a);
      reg_wr(OFS_WRITE_MODE, 32'h6);
      do_acc(24'h000100, 1'b0, 1'b0);
      do_acc(24'h0e0010, 1'b1, 1'b0);
      reg_wr(OFS_WRITE_MODE, 32'h7);
      do_acc(24'h03fffe, 1'b1, 1'b0);
      reg_wr(OFS_FLASH_CFG, 32'h089f);
      do_acc(24'h000200, 1'b0, 1'b0);
      do_acc(24'h000200, 1'b1, 1'b0);
      do_acc(24'h0e8000, 1'b0, 1'b1);
      do_acc(24'h0eebfe, 1'b1, 1'b0);
      do_acc(24'h0ef000, 1'b0, 1'b0);
      do_acc(24'hff0000, 1'b1, 1'b0);
      reg_rd(OFS_STATUS, {28'h0, ZONE_PERIPH, 1'b0});
      reg_wr(OFS_IO_CFG, 32'h0001);
      do_acc(24'hfffb10, 1'b0, 1'b1);
      for (int i = 0; i < 12; i++) begin
         reg_wr(OFS_ZONE_TWO_CFG, (i < 4) ? {16'h0, dir_cfg[i]} : $random(seed));
         reg_wr(OFS_IO_CFG, $random(seed));
         do_acc(24'hfffb00 | (24'($random(seed)) & 24'hff), 1'($random(seed)), 1'($random(seed)));
         do_acc(24'h400000 | (24'($random(seed)) & 24'h3fffff), 1'b0, 1'b1);
         do_acc(24'h400000 | (24'($random(seed)) & 24'h3fffff), 1'($random(seed)), 1'($random(seed)));
      end
      @(posedge mclk_i);
      @(posedge mclk_i);
      finish_test();
   end
endmodule
